// ==== logic/pwr_regs.vh ====
// Purpose: constants for the pwm resolution and period logic
// Assumes: 20 MHz core clock
// Notes: definitions only
`ifndef PWR_REGS_VH
`define PWR_REGS_VH
`define PWR_PER_W 8
`define PWR_DUTY_W 10
`define PWR_PRE_W 2
`define PWR_PRE_DIV1 2'h0
`define PWR_PRE_DIV4 2'h1
`define PWR_PRE_DIV16 2'h2
`define PWR_PER_RST 8'hFF
`define PWR_DUTY_RST 10'h000
`define PWR_RES_W 4
`define PWR_RES_MAX 4'hA
`define PWR_RES_MIN 4'h2
`endif

// ==== logic/pwr_prescaler.v ====
// Purpose: timer prescaler producing a count enable
// Assumes: sel is stable within the core clock domain
// Notes: divide by 1, 4 or 16
`timescale 1ns/10ps
`include "pwr_regs.vh"
module pwr_prescaler (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // control
    input wire [`PWR_PRE_W-1:0] sel,
    input wire restart,
    // tick out
    output wire tick
);
    reg [3:0] cnt_r;
    reg [3:0] cnt_nxt;
    reg [3:0] last;
    always @* begin
        case (sel)
            `PWR_PRE_DIV1: last = 4'h0;
            `PWR_PRE_DIV4: last = 4'h3;
            `PWR_PRE_DIV16: last = 4'hF;
            default: last = 4'hF; // reserved code acts as 16
        endcase
    end
    assign tick = (cnt_r >= last);
    always @* begin
        if (restart || tick) begin
            cnt_nxt = 4'h0;
        end else begin
            cnt_nxt = cnt_r + 4'h1;
        end
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // pwr_prescaler

// ==== logic/pwr_pwm.v ====
// Purpose: pwm generator with period, duty and resolution reporting
// Assumes: control inputs come from same-clock logic
// Notes: 10-bit duty; timer extended by two low bits per period step
//
// Operation
// - Duty has four times (period value plus one) steps: 1024 at period 255, 256 at period 63.
// - Resolution in bits is log2 of four times (period value plus one).
// - Full 10-bit resolution only at period value 255, less below.
// - A duty above the period leaves the pwm pin unchanged.
// - The pacing timer has a prescaler of 1, 4 or 16.
`timescale 1ns/10ps
`include "pwr_regs.vh"
module pwr_pwm (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // control
    input wire enable,
    input wire [`PWR_PRE_W-1:0] prescale_sel,
    input wire [`PWR_PER_W-1:0] pwm_period_register,
    input wire [`PWR_DUTY_W-1:0] duty,
    // outputs
    output reg pwm_out_r,
    output reg period_start_r,
    output reg [`PWR_RES_W-1:0] resolution_r
);
    reg [`PWR_DUTY_W-1:0] cnt_r;
    reg [`PWR_DUTY_W-1:0] cnt_nxt;
    reg [`PWR_DUTY_W-1:0] duty_r;
    reg pwm_nxt;
    wire tick;
    wire [`PWR_DUTY_W-1:0] top;
    wire wrap;
    wire duty_ok;

    // integer bits of log2(4*(p+1)); fractional part is dropped
    function [`PWR_RES_W-1:0] res_bits;
        input [`PWR_PER_W-1:0] p;
        reg [8:0] q;
        integer i;
        begin
            q = {1'b0, p} + 9'h001;
            res_bits = `PWR_RES_MIN;
            for (i = 1; i < 9; i = i + 1) begin
                if (q[i]) begin
                    res_bits = i[`PWR_RES_W-1:0] + `PWR_RES_MIN;
                end
            end
        end
    endfunction

    pwr_prescaler u_pre (
        .core_clk(core_clk),
        .rstn(rstn),
        .sel(prescale_sel),
        .restart(!enable),
        .tick(tick)
    );

    // 10-bit count: prescaled clock extended by 2 bits, 1024 steps max
    assign top = {pwm_period_register, 2'h3};
    assign wrap = tick && (cnt_r == top);
    // live duty compared against full period span at the wrap
    assign duty_ok = (duty <= top);

    always @* begin
        cnt_nxt = cnt_r;
        if (!enable) begin
            cnt_nxt = {`PWR_DUTY_W{1'b0}};
        end else if (wrap || cnt_r > top) begin
            cnt_nxt = {`PWR_DUTY_W{1'b0}};
        end else if (tick) begin
            cnt_nxt = cnt_r + 10'h001;
        end
    end

    always @* begin
        pwm_nxt = pwm_out_r;
        if (!enable) begin
            pwm_nxt = 1'b0;
        end else if (wrap) begin
            // duty out of range: keep the pin as it is
            if (duty_ok) begin
                pwm_nxt = (duty != 10'h000);
            end
        end else if (tick && cnt_nxt == duty_r && duty_ok) begin
            pwm_nxt = 1'b0;
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= `PWR_DUTY_RST;
            duty_r <= `PWR_DUTY_RST;
            pwm_out_r <= 1'b0;
            period_start_r <= 1'b0;
            resolution_r <= `PWR_RES_MAX;
        end else begin
            cnt_r <= cnt_nxt;
            // duty taken at period start, or while disabled, to avoid glitches
            if (wrap || !enable) begin
                duty_r <= duty;
            end
            pwm_out_r <= pwm_nxt;
            period_start_r <= enable && wrap;
            resolution_r <= res_bits(pwm_period_register);
        end
    end
endmodule // pwr_pwm

// ==== verif/pwr_pwm_props.sv ====
// Purpose: pwm checks; Assumes: one clock; Notes: bound below
`timescale 1ns/10ps
module pwr_pwm_props (
    // clocking
    input wire core_clk,
    input wire rstn,
    // control
    input wire enable,
    input wire [1:0] prescale_sel,
    input wire [7:0] pwm_period_register,
    input wire [9:0] duty,
    // outputs
    input wire pwm_out_r,
    input wire period_start_r,
    input wire [3:0] resolution_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire [9:0] lim = {pwm_period_register, 2'h3};
    wire st = period_start_r;
    AST_RES_LOG: assert property (1 |=> resolution_r ==
        $clog2($past(pwm_period_register) + 9'h2) + 1) else $error("res");
    AST_RES_FULL: assert property (&pwm_period_register |=>
        resolution_r == 4'hA) else $error("full");
    AST_WRAP_ON: assert property (st && $past(duty) != 0 &&
        $past(duty) <= $past(lim) |-> pwm_out_r) else $error("on");
    AST_RISE: assert property ($rose(pwm_out_r) |-> st)
        else $error("rise");
    AST_OVER: assert property (st && $past(duty) > $past(lim) |->
        $stable(pwm_out_r)) else $error("over");
    AST_DIV4: assert property (st && prescale_sel == 2'h1 &&
        !pwm_period_register |-> ##16 (st | !enable)) else $error("div");
    cover property (st && pwm_out_r);
    cover property (st && !pwm_out_r);
    cover property (resolution_r == 4'h2);
endmodule // pwr_pwm_props
bind pwr_pwm pwr_pwm_props u_props (.core_clk(core_clk), .rstn(rstn),
    .enable(enable), .prescale_sel(prescale_sel),
    .pwm_period_register(pwm_period_register), .duty(duty),
    .pwm_out_r(pwm_out_r), .period_start_r(period_start_r),
    .resolution_r(resolution_r));

// ==== verif/pwr_tb.sv ====
// Purpose: row-driven bench for the pwm block
// Assumes: 50 ns core clock, inputs driven 5 ns after the edge
// Notes: bounded waits; a timeout counts as a mismatch
`timescale 1ns/10ps
module testbench;
    reg core_clk = 0, rstn = 0, enable = 0;
    reg [23:0] r = 0;
    wire pwm, st;
    wire [3:0] res;
    integer error_cnt = 0, checks = 0, i, n, h, d;
    // rows: resolution, prescale, period, duty
    localparam [143:0] ROWS = 144'hA3FE00_80FC80_787C10_240002_6C5C5F_400FFF;
    pwr_pwm dut (.core_clk(core_clk), .rstn(rstn), .enable(enable),
        .prescale_sel(r[19:18]), .pwm_period_register(r[17:10]),
        .duty(r[9:0]), .pwm_out_r(pwm), .period_start_r(st), .resolution_r(res));
    task chk(input [23:0] nm, input [15:0] s, e);
        checks = checks + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("BAD %s exp %0h seen %0h", nm, e, s);
        end
    endtask
    task conclude;
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #25 core_clk = ~core_clk;
    initial begin
        repeat (16) @(posedge core_clk) #5;
        chk("rst", res, 4'hA);
        chk("pwm", pwm, 1'b0);
        chk("st", st, 1'b0);
        rstn = 1;
        // last row has duty above period: pin must stay low
        for (i = 5; i >= 0; i = i - 1) begin
            r = ROWS[i*24 +: 24];
            enable = 1;
            for (n = 0; !st && n < 4000; n++) @(posedge core_clk) #5;
            if (st !== 1'b1) begin
                error_cnt = error_cnt + 1;
                conclude;
            end
            d = r[19:18] == 0 ? 1 : r[19:18] == 1 ? 4 : 16;
            h = 0;
            for (n = 0; !n || !st && n < 9000; n++) begin
                h = h + pwm;
                @(posedge core_clk) #5;
            end
            if (st !== 1'b1) begin
                error_cnt = error_cnt + 1;
                conclude;
            end
            chk("per", n, 4 * (r[17:10] + 1) * d);
            chk("hi", h, r[9:0] > 4 * r[17:10] + 3 ? 0 : r[9:0] * d);
            chk("res", res, r[23:20]);
            enable = 0;
            repeat (20) @(posedge core_clk) #5;
        end
        conclude;
    end
endmodule // testbench
